// [encoder_config_object_bank.sv]
// Summary of operation
// RQ1 - object 2200 reads back the shared cyclic timer value, read only
// RQ2 - save code written to 2300 stores parameters, then requests reset
// RQ3 - node number output equals stored value plus one, default 1fh
// RQ4 - bus rate byte 00h..07h decodes to 20..1000 kbit/s
// RQ5 - boolean object drives termination switch, off by default, restored
// RQ6 - speed measurement off until enable subindex written nonzero
// RQ7 - speed filter 0/1/2 gives 5/50/500 ms window
// RQ8 - speed result is signed 32-bit read only, not restored
// RQ9 - acceleration measurement off until enable subindex written nonzero
// RQ10 - acceleration filter 0/1/2 gives 40/120/750 ms window
// RQ11 - acceleration result is signed 32-bit read only
// RQ12 - legacy enable may be set only after unlock code written; a storage restore loads it without the unlock
// RQ13 - loader code written to 4000 erases storage, then requests reset
// RQ14 - loader mode uses node 1 and 125 kbit/s
// RQ15 - loader mode hides objects and stops encoder behaviour
// RQ16 - operating word selects counting direction
// RQ17 - scaling bit selects scaled or raw position
// RQ18 - direction bit is bit 0, 1 means counter-clockwise increasing
// RQ19 - scaling bit 0 disables, 1 enables scaling
// RQ20 - out-of-range rate or filter writes abort, value unchanged
module encoder_config_object_bank #(
	parameter int unsigned SPD_WIN0 = int'(enc_cfg_pkg::SPD_DLY0_MS * enc_cfg_pkg::CLK_HZ / 1000),
	parameter int unsigned SPD_WIN1 = int'(enc_cfg_pkg::SPD_DLY1_MS * enc_cfg_pkg::CLK_HZ / 1000),
	parameter int unsigned SPD_WIN2 = int'(enc_cfg_pkg::SPD_DLY2_MS * enc_cfg_pkg::CLK_HZ / 1000),
	parameter int unsigned ACC_WIN0 = int'(enc_cfg_pkg::ACC_DLY0_MS * enc_cfg_pkg::CLK_HZ / 1000),
	parameter int unsigned ACC_WIN1 = int'(enc_cfg_pkg::ACC_DLY1_MS * enc_cfg_pkg::CLK_HZ / 1000),
	parameter int unsigned ACC_WIN2 = int'(enc_cfg_pkg::ACC_DLY2_MS * enc_cfg_pkg::CLK_HZ / 1000)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// object access request
	input wire logic req,
	input wire logic req_wr,
	input wire logic [15:0] req_index,
	input wire logic [7:0] req_sub,
	input wire logic [31:0] req_wdata,
	// object access answer
	output logic rsp_valid,
	output logic [31:0] rsp_rdata,
	output logic [31:0] rsp_abort,
	// shared values from the rest of the device
	input wire logic [15:0] cyc_time,
	input wire logic [31:0] pos_count,
	input wire logic loader_boot,
	// non-volatile storage
	input wire logic nv_load,
	input wire logic [enc_cfg_pkg::NV_W-1:0] nv_image_in,
	output logic [enc_cfg_pkg::NV_W-1:0] nv_image_out,
	output logic nv_store_req,
	output logic nv_erase_req,
	input wire logic nv_done,
	output logic reset_req,
	// settings to the device
	output logic [7:0] node_id,
	output logic [9:0] bus_rate_kbps,
	output logic term_on,
	output logic legacy_mode_enable,
	output logic count_ccw,
	output logic scaling_enable_bit,
	output logic encoder_run,
	output logic [31:0] speed_result,
	output logic [31:0] accel_result
);
	typedef struct packed {
		enc_cfg_pkg::ctl_e st;
		logic init;
		logic loader;
		logic unlock;
		logic [7:0] node;
		logic [7:0] rate;
		logic [7:0] spd_en;
		logic [7:0] spd_set;
		logic [7:0] acc_en;
		logic [7:0] acc_set;
		logic term;
		logic legacy;
		logic [1:0] op;
		logic rsp_v;
		logic [31:0] rdata;
		logic [31:0] abort;
	} bank_s;
	bank_s s_q;
	bank_s s_d;
	logic wr_ok;
	logic sub0;

	meas_if spd ();
	meas_if acc ();

	// rate byte to kbit/s
	function automatic logic [9:0] rate_kbps(input logic [7:0] code);
		case (code)
			8'h00: rate_kbps = 10'd20;
			8'h01: rate_kbps = 10'd50;
			8'h02: rate_kbps = 10'd100;
			8'h03: rate_kbps = 10'd125;
			8'h04: rate_kbps = 10'd250;
			8'h05: rate_kbps = 10'd500;
			8'h06: rate_kbps = 10'd800;
			8'h07: rate_kbps = 10'd1000;
			default: rate_kbps = 10'd125;
		endcase
	endfunction

	assign sub0 = (req_sub == 8'h00);

	// request decode, storage sequencing and restore
	always_comb
	begin
		s_d = s_q;
		s_d.rsp_v = 1'b0;
		wr_ok = 1'b0;
		if (!s_q.init)
		begin
			s_d.init = 1'b1;
			s_d.loader = loader_boot; // RQ14
		end
		if (nv_load && !s_q.loader && s_q.st == enc_cfg_pkg::CTL_IDLE)
		begin
			s_d.node = nv_image_in[enc_cfg_pkg::NV_NODE +: 8];
			s_d.rate = nv_image_in[enc_cfg_pkg::NV_RATE +: 8];
			s_d.spd_en = nv_image_in[enc_cfg_pkg::NV_SPD_EN +: 8];
			s_d.spd_set = nv_image_in[enc_cfg_pkg::NV_SPD_SET +: 8];
			s_d.acc_en = nv_image_in[enc_cfg_pkg::NV_ACC_EN +: 8];
			s_d.acc_set = nv_image_in[enc_cfg_pkg::NV_ACC_SET +: 8];
			s_d.op = nv_image_in[enc_cfg_pkg::NV_OP +: 2];
			s_d.term = nv_image_in[enc_cfg_pkg::NV_TERM]; // RQ5
			s_d.legacy = nv_image_in[enc_cfg_pkg::NV_LEGACY];
		end
		// storage sequence: store or erase, then hold reset request
		case (s_q.st)
			enc_cfg_pkg::CTL_IDLE: ;
			enc_cfg_pkg::CTL_STORE,
			enc_cfg_pkg::CTL_ERASE:
			begin
				if (nv_done)
					s_d.st = enc_cfg_pkg::CTL_RESET; // RQ2 RQ13
			end
			enc_cfg_pkg::CTL_RESET: ;
			default: s_d.st = enc_cfg_pkg::CTL_IDLE;
		endcase
		if (req)
		begin
			s_d.rsp_v = 1'b1;
			s_d.rdata = 32'h0;
			s_d.abort = enc_cfg_pkg::ABT_NONE;
			if (s_q.loader)
				s_d.abort = enc_cfg_pkg::ABT_NOOBJ; // RQ15
			else if (s_q.st != enc_cfg_pkg::CTL_IDLE)
				s_d.abort = enc_cfg_pkg::ABT_STATE;
			else
			begin
				case (req_index)
					enc_cfg_pkg::IDX_EVT_MIRROR:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (req_wr)
							s_d.abort = enc_cfg_pkg::ABT_RO;
						else
							s_d.rdata = {16'h0, cyc_time}; // RQ1
					end
					enc_cfg_pkg::IDX_SAVE_RST:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (!req_wr)
							s_d.abort = enc_cfg_pkg::ABT_WO;
						else if (req_wdata == enc_cfg_pkg::SAVE_CODE)
							s_d.st = enc_cfg_pkg::CTL_STORE; // RQ2
						else
							s_d.abort = enc_cfg_pkg::ABT_STORE;
					end
					enc_cfg_pkg::IDX_NODE:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (req_wr)
							s_d.node = req_wdata[7:0];
						else
							s_d.rdata = {24'h0, s_q.node};
					end
					enc_cfg_pkg::IDX_RATE:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (!req_wr)
							s_d.rdata = {24'h0, s_q.rate};
						else if (req_wdata > {24'h0, enc_cfg_pkg::RATE_MAX})
							s_d.abort = enc_cfg_pkg::ABT_RANGE; // RQ20
						else
							s_d.rate = req_wdata[7:0];
					end
					enc_cfg_pkg::IDX_TERM:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (!req_wr)
							s_d.rdata = {31'h0, s_q.term};
						else if (req_wdata > 32'h1)
							s_d.abort = enc_cfg_pkg::ABT_RANGE;
						else
							s_d.term = req_wdata[0]; // RQ5
					end
					enc_cfg_pkg::IDX_SPD_CTL,
					enc_cfg_pkg::IDX_ACC_CTL:
					begin
						wr_ok = req_wr && req_sub != 8'h00;
						if (req_sub > 8'h02)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (sub0 && req_wr)
							s_d.abort = enc_cfg_pkg::ABT_RO;
						else if (!req_wr)
						begin
							case ({req_index == enc_cfg_pkg::IDX_ACC_CTL, req_sub[1:0]})
								3'b001: s_d.rdata = {24'h0, s_q.spd_en};
								3'b010: s_d.rdata = {24'h0, s_q.spd_set};
								3'b101: s_d.rdata = {24'h0, s_q.acc_en};
								3'b110: s_d.rdata = {24'h0, s_q.acc_set};
								default: s_d.rdata = {24'h0, enc_cfg_pkg::SUBCNT_CTL};
							endcase
						end
						else if (req_sub == 8'h02 && req_wdata > {24'h0, enc_cfg_pkg::FILT_MAX})
							s_d.abort = enc_cfg_pkg::ABT_RANGE; // RQ20
						else if (wr_ok && req_index == enc_cfg_pkg::IDX_SPD_CTL)
						begin
							if (req_sub == 8'h01)
								s_d.spd_en = req_wdata[7:0]; // RQ6
							else
								s_d.spd_set = req_wdata[7:0]; // RQ7
						end
						else if (wr_ok)
						begin
							if (req_sub == 8'h01)
								s_d.acc_en = req_wdata[7:0]; // RQ9
							else
								s_d.acc_set = req_wdata[7:0]; // RQ10
						end
					end
					enc_cfg_pkg::IDX_SPD_VAL,
					enc_cfg_pkg::IDX_ACC_VAL:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (req_wr)
							s_d.abort = enc_cfg_pkg::ABT_RO; // RQ8 RQ11
						else if (req_index == enc_cfg_pkg::IDX_SPD_VAL)
							s_d.rdata = spd.result;
						else
							s_d.rdata = acc.result;
					end
					enc_cfg_pkg::IDX_LEGACY:
					begin
						if (req_sub > 8'h01)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (!req_wr)
							s_d.rdata = sub0 ? enc_cfg_pkg::UNLOCK_CODE : {31'h0, s_q.legacy};
						else if (sub0)
						begin
							if (req_wdata == enc_cfg_pkg::UNLOCK_CODE)
								s_d.unlock = 1'b1; // RQ12
							else
								s_d.abort = enc_cfg_pkg::ABT_STORE;
						end
						else if (req_wdata > 32'h1)
							s_d.abort = enc_cfg_pkg::ABT_RANGE;
						else if (req_wdata[0] && !s_q.unlock)
							s_d.abort = enc_cfg_pkg::ABT_STATE; // RQ12
						else
							s_d.legacy = req_wdata[0];
					end
					enc_cfg_pkg::IDX_LOADER:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (!req_wr)
							s_d.abort = enc_cfg_pkg::ABT_WO;
						else if (req_wdata == enc_cfg_pkg::LOADER_CODE)
							s_d.st = enc_cfg_pkg::CTL_ERASE; // RQ13
						else
							s_d.abort = enc_cfg_pkg::ABT_STORE;
					end
					enc_cfg_pkg::IDX_OP_WORD:
					begin
						if (!sub0)
							s_d.abort = enc_cfg_pkg::ABT_SUB;
						else if (req_wr)
							s_d.op = {req_wdata[enc_cfg_pkg::OP_SFC_BIT],
								req_wdata[enc_cfg_pkg::OP_CS_BIT]}; // RQ16 RQ18 RQ19
						else
							s_d.rdata = {30'h0, s_q.op};
					end
					default: s_d.abort = enc_cfg_pkg::ABT_NOOBJ;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q <= '0;
			s_q.st <= enc_cfg_pkg::CTL_IDLE;
			s_q.node <= enc_cfg_pkg::NODE_RST;
			s_q.rate <= enc_cfg_pkg::RATE_RST;
		end
		else
			s_q <= s_d;
	end

	// measurement channels, halted in loader mode
	assign spd.en = (s_q.spd_en != 8'h00) && !s_q.loader; // RQ6 RQ15
	assign spd.setting = s_q.spd_set[1:0]; // RQ7
	assign spd.sample = pos_count;
	assign acc.en = (s_q.acc_en != 8'h00) && !s_q.loader; // RQ9 RQ15
	assign acc.setting = s_q.acc_set[1:0]; // RQ10
	assign acc.sample = spd.result;

	rate_meter #(.WIN0(SPD_WIN0), .WIN1(SPD_WIN1), .WIN2(SPD_WIN2)) u_speed (
		.clk(clk),
		.rst_b(rst_b),
		.m(spd.meter)
	);

	rate_meter #(.WIN0(ACC_WIN0), .WIN1(ACC_WIN1), .WIN2(ACC_WIN2)) u_accel (
		.clk(clk),
		.rst_b(rst_b),
		.m(acc.meter)
	);

	// outputs
	assign rsp_valid = s_q.rsp_v;
	assign rsp_rdata = s_q.rdata;
	assign rsp_abort = s_q.abort;
	assign nv_store_req = (s_q.st == enc_cfg_pkg::CTL_STORE); // RQ2
	assign nv_erase_req = (s_q.st == enc_cfg_pkg::CTL_ERASE); // RQ13
	assign reset_req = (s_q.st == enc_cfg_pkg::CTL_RESET);
	assign node_id = s_q.loader ? enc_cfg_pkg::LOADER_NODE : s_q.node + 8'h01; // RQ3 RQ14
	assign bus_rate_kbps = s_q.loader ? enc_cfg_pkg::LOADER_KBPS : rate_kbps(s_q.rate); // RQ4 RQ14
	assign term_on = s_q.term;
	assign legacy_mode_enable = s_q.legacy;
	assign count_ccw = s_q.op[0]; // RQ18
	assign scaling_enable_bit = s_q.op[1]; // RQ17
	assign encoder_run = s_q.init && !s_q.loader; // RQ15
	assign speed_result = spd.result;
	assign accel_result = acc.result;
	assign nv_image_out = {12'h0, s_q.legacy, s_q.term, s_q.op, s_q.acc_set, s_q.acc_en,
		s_q.spd_set, s_q.spd_en, s_q.rate, s_q.node};

	// checks
	a_node_plus_one: assert property (@(posedge clk) disable iff (!rst_b)
		req && req_wr && req_index == enc_cfg_pkg::IDX_NODE && sub0 && !s_q.loader
		&& s_q.st == enc_cfg_pkg::CTL_IDLE |=> node_id == $past(req_wdata[7:0]) + 8'h01) // RQ3
		else $error("node id not stored value plus one");
	a_rate_range_abort: assert property (@(posedge clk) disable iff (!rst_b)
		req && req_wr && req_index == enc_cfg_pkg::IDX_RATE && sub0 && req_wdata > 32'h7 && !s_q.loader
		&& s_q.st == enc_cfg_pkg::CTL_IDLE |=> rsp_abort == enc_cfg_pkg::ABT_RANGE && $stable(bus_rate_kbps)) // RQ20
		else $error("bad rate code not refused");
	a_save_starts: assert property (@(posedge clk) disable iff (!rst_b)
		req && req_wr && req_index == enc_cfg_pkg::IDX_SAVE_RST && sub0
		&& req_wdata == enc_cfg_pkg::SAVE_CODE && !s_q.loader
		&& s_q.st == enc_cfg_pkg::CTL_IDLE |=> nv_store_req && !reset_req) // RQ2
		else $error("save code did not start store");
	a_reset_after_nv: assert property (@(posedge clk) disable iff (!rst_b)
		(nv_store_req || nv_erase_req) && nv_done |=> reset_req ##1 reset_req) // RQ2
		else $error("no reset request after storage done");
	a_mirror_read: assert property (@(posedge clk) disable iff (!rst_b)
		req && !req_wr && req_index == enc_cfg_pkg::IDX_EVT_MIRROR && sub0 && !s_q.loader
		&& s_q.st == enc_cfg_pkg::CTL_IDLE |=> rsp_rdata == {16'h0, $past(cyc_time)}) // RQ1
		else $error("mirror read wrong");
	a_legacy_locked: assert property (@(posedge clk) disable iff (!rst_b)
		req && req_wr && req_index == enc_cfg_pkg::IDX_LEGACY && req_sub == 8'h01
		&& req_wdata == 32'h1 && !s_q.unlock && !legacy_mode_enable
		|=> !legacy_mode_enable && rsp_abort != enc_cfg_pkg::ABT_NONE) // RQ12
		else $error("legacy enabled without unlock");
	a_loader_fixed: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.loader |-> node_id == 8'h01 && bus_rate_kbps == 10'd125 && !encoder_run) // RQ14 RQ15
		else $error("loader mode settings wrong");
	a_op_word_bits: assert property (@(posedge clk) disable iff (!rst_b)
		req && req_wr && req_index == enc_cfg_pkg::IDX_OP_WORD && sub0 && !s_q.loader
		&& s_q.st == enc_cfg_pkg::CTL_IDLE
		|=> count_ccw == $past(req_wdata[0]) && scaling_enable_bit == $past(req_wdata[1])) // RQ18 RQ19
		else $error("operating word bits not applied");
	a_answer_next: assert property (@(posedge clk) disable iff (!rst_b)
		req |=> rsp_valid) // RQ20
		else $error("no answer one cycle after request");
	c_save_reset: cover property (@(posedge clk) disable iff (!rst_b) nv_store_req ##[1:20] reset_req);
	c_erase: cover property (@(posedge clk) disable iff (!rst_b) nv_erase_req);
	c_range: cover property (@(posedge clk) disable iff (!rst_b)
		rsp_valid && rsp_abort == enc_cfg_pkg::ABT_RANGE);
	c_legacy_on: cover property (@(posedge clk) disable iff (!rst_b) $rose(legacy_mode_enable));
endmodule // encoder_config_object_bank

// [enc_cfg_pkg.sv]
package enc_cfg_pkg;
	// object indices
	localparam logic [15:0] IDX_EVT_MIRROR = 16'h2200;
	localparam logic [15:0] IDX_SAVE_RST = 16'h2300;
	localparam logic [15:0] IDX_NODE = 16'h3000;
	localparam logic [15:0] IDX_RATE = 16'h3001;
	localparam logic [15:0] IDX_TERM = 16'h3002;
	localparam logic [15:0] IDX_SPD_CTL = 16'h3010;
	localparam logic [15:0] IDX_SPD_VAL = 16'h3011;
	localparam logic [15:0] IDX_ACC_CTL = 16'h3020;
	localparam logic [15:0] IDX_ACC_VAL = 16'h3021;
	localparam logic [15:0] IDX_LEGACY = 16'h3030;
	localparam logic [15:0] IDX_LOADER = 16'h4000;
	localparam logic [15:0] IDX_OP_WORD = 16'h6000;
	// access codes
	localparam logic [31:0] SAVE_CODE = 32'h55aaaa55;
	localparam logic [31:0] UNLOCK_CODE = 32'h47111147;
	localparam logic [31:0] LOADER_CODE = 32'h47111147;
	// reset values, subindex count and range limits
	localparam logic [7:0] NODE_RST = 8'h1f;
	localparam logic [7:0] RATE_RST = 8'h03;
	localparam logic [7:0] SUBCNT_CTL = 8'h02;
	localparam logic [7:0] RATE_MAX = 8'h07;
	localparam logic [7:0] FILT_MAX = 8'h02;
	// loader mode fixed link settings
	localparam logic [7:0] LOADER_NODE = 8'h01;
	localparam logic [9:0] LOADER_KBPS = 10'd125;
	// operating word fields
	localparam int OP_CS_BIT = 0;
	localparam int OP_SFC_BIT = 1;
	// abort codes, zero means success
	localparam logic [31:0] ABT_NONE = 32'h00000000;
	localparam logic [31:0] ABT_WO = 32'h06010001;
	localparam logic [31:0] ABT_RO = 32'h06010002;
	localparam logic [31:0] ABT_NOOBJ = 32'h06020000;
	localparam logic [31:0] ABT_SUB = 32'h06090011;
	localparam logic [31:0] ABT_RANGE = 32'h06090030;
	localparam logic [31:0] ABT_STORE = 32'h08000020;
	localparam logic [31:0] ABT_STATE = 32'h08000022;
	// non-volatile image layout
	localparam int NV_W = 64;
	localparam int NV_NODE = 0;
	localparam int NV_RATE = 8;
	localparam int NV_SPD_EN = 16;
	localparam int NV_SPD_SET = 24;
	localparam int NV_ACC_EN = 32;
	localparam int NV_ACC_SET = 40;
	localparam int NV_OP = 48;
	localparam int NV_TERM = 50;
	localparam int NV_LEGACY = 51;
	// timing
	localparam longint CLK_HZ = 100_000_000;
	localparam longint SPD_DLY0_MS = 5;
	localparam longint SPD_DLY1_MS = 50;
	localparam longint SPD_DLY2_MS = 500;
	localparam longint ACC_DLY0_MS = 40;
	localparam longint ACC_DLY1_MS = 120;
	localparam longint ACC_DLY2_MS = 750;
	localparam int WIN_W = 27;
	// controller states
	typedef enum logic [1:0] {
		CTL_IDLE = 2'b00,
		CTL_STORE = 2'b01,
		CTL_ERASE = 2'b10,
		CTL_RESET = 2'b11
	} ctl_e;
endpackage

// [meas_if.sv]
interface meas_if;
	logic en;
	logic [1:0] setting;
	logic [31:0] sample;
	logic [31:0] result;
	modport meter (input en, input setting, input sample, output result);
	modport ctrl (output en, output setting, output sample, input result);
endinterface

// [rate_meter.sv]
module rate_meter #(
	parameter int unsigned WIN0 = 500000,
	parameter int unsigned WIN1 = 5000000,
	parameter int unsigned WIN2 = 50000000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control and result
	meas_if.meter m
);
	typedef struct packed {
		logic [enc_cfg_pkg::WIN_W-1:0] cnt;
		logic [31:0] last;
		logic [31:0] res;
	} meter_s;
	meter_s s_q;
	meter_s s_d;
	logic [enc_cfg_pkg::WIN_W-1:0] win_end;

	// window length from filter setting
	always_comb
	begin
		case (m.setting)
			2'd1: win_end = enc_cfg_pkg::WIN_W'(WIN1 - 1);
			2'd2: win_end = enc_cfg_pkg::WIN_W'(WIN2 - 1);
			default: win_end = enc_cfg_pkg::WIN_W'(WIN0 - 1);
		endcase
	end

	// difference of sample over one window
	always_comb
	begin
		s_d = s_q;
		if (!m.en)
		begin
			s_d.cnt = '0;
			s_d.last = m.sample;
			s_d.res = '0;
		end
		else if (s_q.cnt >= win_end)
		begin
			s_d.cnt = '0;
			s_d.last = m.sample;
			s_d.res = m.sample - s_q.last;
		end
		else
		begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign m.result = s_q.res;

	a_meter_off_zero: assert property (@(posedge clk) disable iff (!rst_b)
		!m.en |=> m.result == 32'h0) // RQ6
		else $error("result not zero while measurement disabled");
endmodule // rate_meter

// [sdo_master_model.sv]
module sdo_master_model
(
	// clock
	input wire logic clk,
	// answer from the bank
	input wire logic rsp_valid,
	input wire logic [31:0] rsp_rdata,
	input wire logic [31:0] rsp_abort,
	// request to the bank
	output logic req,
	output logic req_wr,
	output logic [15:0] req_index,
	output logic [7:0] req_sub,
	output logic [31:0] req_wdata
);
	timeunit 1ns;
	timeprecision 100ps;

	// request lines idle at time zero
	initial
	begin
		req = 1'b0;
		req_wr = 1'b0;
		req_index = 16'h0000;
		req_sub = 8'h00;
		req_wdata = 32'h00000000;
	end

	// one transfer: one-cycle request, answer taken the cycle after
	task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
		output logic seen, output logic [31:0] rd, output logic [31:0] ab);
		@(posedge clk);
		#1;
		req = 1'b1;
		req_wr = wr;
		req_index = idx;
		req_sub = sub;
		req_wdata = wd;
		@(posedge clk);
		#1;
		seen = rsp_valid;
		rd = rsp_rdata;
		ab = rsp_abort;
		// released lines show no stale value
		req = 1'b0;
		req_wr = ~wr;
		req_index = ~idx;
		req_sub = ~sub;
		req_wdata = ~wd;
	endtask
endmodule // sdo_master_model

// [encoder_config_object_bank_tb.sv]
module encoder_config_object_bank_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rst_b, req, req_wr, rsp_valid, loader_boot, nv_load, nv_store_req, nv_erase_req, nv_done, reset_req;
	logic [15:0] req_index, cyc_time;
	logic [7:0] req_sub, node_id;
	logic [31:0] req_wdata, rsp_rdata, rsp_abort, pos_count, speed_result, accel_result;
	logic [63:0] nv_image_in, nv_image_out;
	logic [9:0] bus_rate_kbps;
	logic term_on, legacy_mode_enable, count_ccw, scaling_enable_bit, encoder_run;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [9:0] kbps [8] = '{10'h014, 10'h032, 10'h064, 10'h07d, 10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
	logic [31:0] swin [3] = '{32'h8, 32'h10, 32'h20};

	encoder_config_object_bank #(.SPD_WIN0(8), .SPD_WIN1(16), .SPD_WIN2(32), .ACC_WIN0(8), .ACC_WIN1(16))
		u_encoder_config_object_bank (.clk(clk), .rst_b(rst_b), .req(req), .req_wr(req_wr),
		.req_index(req_index), .req_sub(req_sub), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .rsp_abort(rsp_abort), .cyc_time(cyc_time), .pos_count(pos_count),
		.loader_boot(loader_boot), .nv_load(nv_load), .nv_image_in(nv_image_in), .nv_image_out(nv_image_out),
		.nv_store_req(nv_store_req), .nv_erase_req(nv_erase_req), .nv_done(nv_done), .reset_req(reset_req),
		.node_id(node_id), .bus_rate_kbps(bus_rate_kbps), .term_on(term_on),
		.legacy_mode_enable(legacy_mode_enable), .count_ccw(count_ccw), .scaling_enable_bit(scaling_enable_bit),
		.encoder_run(encoder_run), .speed_result(speed_result), .accel_result(accel_result));

	sdo_master_model u_sdo_master_model (.clk(clk), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.rsp_abort(rsp_abort), .req(req), .req_wr(req_wr), .req_index(req_index), .req_sub(req_sub),
		.req_wdata(req_wdata));

	// clock and cycle ceiling
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		pos_count <= pos_count + 32'h1; // shaft turning one step a cycle
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	// verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one object access with its expected answer
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
		input logic [31:0] exp_rd, input logic [31:0] exp_ab);
		logic v;
		logic [31:0] rd, ab;
		u_sdo_master_model.access(wr, idx, sub, wd, v, rd, ab);
		chk("rsp_valid", {31'h0, v}, 32'h1);
		chk("rsp_rdata", rd, exp_rd);
		chk("rsp_abort", ab, exp_ab);
	endtask

	task automatic do_reset(input logic lb);
		rst_b = 1'b0;
		loader_boot = lb;
		repeat (12) @(posedge clk);
		#1;
		rst_b = 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic pulse_done();
		@(posedge clk);
		#1;
		nv_done = 1'b1;
		@(posedge clk);
		#1;
		nv_done = 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic t_defaults();
		chk("node_id", {24'h0, node_id}, 32'h20);
		chk("term_on", {31'h0, term_on}, 32'h0);
		chk("speed_result", speed_result, 32'h0);
		chk("encoder_run", {31'h0, encoder_run}, 32'h1);
		xfer(1'b0, 16'h3000, 8'h00, 32'h0, 32'h1f, enc_cfg_pkg::ABT_NONE);
		xfer(1'b0, 16'h3010, 8'h02, 32'h0, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b0, 16'h3020, 8'h01, 32'h0, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b0, 16'h6000, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b0, 16'h3030, 8'h00, 32'h0, enc_cfg_pkg::UNLOCK_CODE, enc_cfg_pkg::ABT_NONE);
		xfer(1'b0, 16'h2300, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_WO);
		xfer(1'b0, 16'h4000, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_WO);
		xfer(1'b0, 16'h2201, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_NOOBJ);
		xfer(1'b0, 16'h3000, 8'h01, 32'h0, 32'h0, enc_cfg_pkg::ABT_SUB);
	endtask

	task automatic t_mirror();
		cyc_time = 16'h1234;
		xfer(1'b0, 16'h2200, 8'h00, 32'h0, 32'h1234, enc_cfg_pkg::ABT_NONE);
		xfer(1'b1, 16'h2200, 8'h00, 32'h5, 32'h0, enc_cfg_pkg::ABT_RO);
		cyc_time = 16'h00c8;
		xfer(1'b0, 16'h2200, 8'h00, 32'h0, 32'hc8, enc_cfg_pkg::ABT_NONE);
		xfer(1'b1, 16'h3011, 8'h00, 32'h5, 32'h0, enc_cfg_pkg::ABT_RO);
		xfer(1'b1, 16'h3021, 8'h00, 32'h5, 32'h0, enc_cfg_pkg::ABT_RO);
	endtask

	task automatic t_node_rate();
		xfer(1'b1, 16'h3000, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_NONE);
		chk("node_id", {24'h0, node_id}, 32'h01);
		for (int i = 0; i < 8; i++)
		begin
			xfer(1'b1, 16'h3001, 8'h00, i, 32'h0, enc_cfg_pkg::ABT_NONE);
			chk("bus_rate_kbps", {22'h0, bus_rate_kbps}, {22'h0, kbps[i]});
		end
		xfer(1'b1, 16'h3001, 8'h00, 32'h8, 32'h0, enc_cfg_pkg::ABT_RANGE);
		xfer(1'b0, 16'h3001, 8'h00, 32'h0, 32'h7, enc_cfg_pkg::ABT_NONE);
		chk("bus_rate_kbps", {22'h0, bus_rate_kbps}, 32'h3e8);
	endtask

	task automatic t_op_term();
		xfer(1'b1, 16'h6000, 8'h00, 32'h1, 32'h0, enc_cfg_pkg::ABT_NONE);
		chk("ccw_scale", {30'h0, scaling_enable_bit, count_ccw}, 32'h1);
		xfer(1'b1, 16'h6000, 8'h00, 32'h2, 32'h0, enc_cfg_pkg::ABT_NONE);
		chk("ccw_scale", {30'h0, scaling_enable_bit, count_ccw}, 32'h2);
		xfer(1'b1, 16'h3002, 8'h00, 32'h1, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b1, 16'h3002, 8'h00, 32'h2, 32'h0, enc_cfg_pkg::ABT_RANGE);
		chk("term_on", {31'h0, term_on}, 32'h1);
	endtask

	task automatic t_legacy();
		xfer(1'b1, 16'h3030, 8'h01, 32'h1, 32'h0, enc_cfg_pkg::ABT_STATE);
		chk("legacy", {31'h0, legacy_mode_enable}, 32'h0);
		xfer(1'b1, 16'h3030, 8'h00, 32'h47111148, 32'h0, enc_cfg_pkg::ABT_STORE);
		xfer(1'b1, 16'h3030, 8'h00, enc_cfg_pkg::UNLOCK_CODE, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b1, 16'h3030, 8'h01, 32'h1, 32'h0, enc_cfg_pkg::ABT_NONE);
		chk("legacy", {31'h0, legacy_mode_enable}, 32'h1);
	endtask

	task automatic t_measure();
		logic hit = 1'b0;
		for (int s = 0; s < 3; s++)
		begin
			xfer(1'b1, 16'h3010, 8'h02, s, 32'h0, enc_cfg_pkg::ABT_NONE);
			xfer(1'b1, 16'h3010, 8'h01, 32'h1, 32'h0, enc_cfg_pkg::ABT_NONE);
			repeat (3 * swin[s] + 4) @(posedge clk);
			#1;
			chk("speed_result", speed_result, swin[s]);
			xfer(1'b0, 16'h3011, 8'h00, 32'h0, swin[s], enc_cfg_pkg::ABT_NONE);
		end
		xfer(1'b1, 16'h3010, 8'h02, 32'h3, 32'h0, enc_cfg_pkg::ABT_RANGE);
		xfer(1'b1, 16'h3020, 8'h02, 32'h3, 32'h0, enc_cfg_pkg::ABT_RANGE);
		xfer(1'b1, 16'h3020, 8'h02, 32'h1, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b1, 16'h3020, 8'h01, 32'h1, 32'h0, enc_cfg_pkg::ABT_NONE);
		repeat (40) @(posedge clk);
		#1;
		chk("accel_result", accel_result, 32'h0);
		xfer(1'b0, 16'h3021, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_NONE);
		xfer(1'b1, 16'h3010, 8'h01, 32'h0, 32'h0, enc_cfg_pkg::ABT_NONE);
		@(posedge clk);
		#1;
		chk("speed_result", speed_result, 32'h0);
		repeat (20)
		begin
			@(posedge clk);
			#1;
			hit = hit | (accel_result == 32'hffffffe0);
		end
		chk("accel_step", {31'h0, hit}, 32'h1);
	endtask

	task automatic t_restore_save();
		nv_image_in = {12'h0, 1'b0, 1'b0, 2'b01, 32'h0, 8'h04, 8'h05};
		nv_load = 1'b1;
		@(posedge clk);
		#1;
		nv_load = 1'b0;
		@(posedge clk);
		#1;
		chk("node_id", {24'h0, node_id}, 32'h06);
		chk("bus_rate_kbps", {22'h0, bus_rate_kbps}, 32'hfa);
		chk("restored", {28'h0, term_on, legacy_mode_enable, scaling_enable_bit, count_ccw}, 32'h1);
		xfer(1'b1, 16'h2300, 8'h00, 32'h55aaaa54, 32'h0, enc_cfg_pkg::ABT_STORE);
		xfer(1'b1, 16'h2300, 8'h00, enc_cfg_pkg::SAVE_CODE, 32'h0, enc_cfg_pkg::ABT_NONE);
		chk("nv_store_req", {31'h0, nv_store_req}, 32'h1);
		chk("nv_image_out", nv_image_out[31:0], 32'h0405);
		xfer(1'b0, 16'h3000, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_STATE);
		pulse_done();
		chk("store_reset", {30'h0, nv_store_req, reset_req}, 32'h1);
		do_reset(1'b0);
		chk("reset_req", {31'h0, reset_req}, 32'h0);
	endtask

	task automatic t_loader();
		xfer(1'b1, 16'h4000, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_STORE);
		xfer(1'b1, 16'h4000, 8'h00, enc_cfg_pkg::LOADER_CODE, 32'h0, enc_cfg_pkg::ABT_NONE);
		chk("nv_erase_req", {31'h0, nv_erase_req}, 32'h1);
		pulse_done();
		chk("erase_reset", {30'h0, nv_erase_req, reset_req}, 32'h1);
		do_reset(1'b1);
		chk("node_id", {24'h0, node_id}, 32'h01);
		chk("bus_rate_kbps", {22'h0, bus_rate_kbps}, 32'h7d);
		chk("encoder_run", {31'h0, encoder_run}, 32'h0);
		xfer(1'b0, 16'h3000, 8'h00, 32'h0, 32'h0, enc_cfg_pkg::ABT_NOOBJ);
		do_reset(1'b0);
		chk("encoder_run", {31'h0, encoder_run}, 32'h1);
	endtask

	// main sequence
	initial
	begin
		cyc_time = 16'h0064;
		pos_count = 32'h0;
		nv_load = 1'b0;
		nv_done = 1'b0;
		nv_image_in = 64'h0;
		do_reset(1'b0);
		t_defaults();
		t_mirror();
		t_node_rate();
		t_op_term();
		t_legacy();
		t_measure();
		t_restore_save();
		t_loader();
		end_of_test();
	end
endmodule // encoder_config_object_bank_tb
